// File: rtl/cbs_pkg.sv
// Constants, register map and field layout for the CAN buffer status and control block
// What this block does
// - Extended-id mask bit 1 includes that id bit in compare, 0 ignores it
// - Storing a message into buffers 0-15 sets its full flag, low register
// - Buffers 16-31 full flags sit in bits 0-15 of the high register
// - Full and overflow flags clear on written zero; written one leaves them alone
// - Storing into a buffer already full sets its overflow flag
// - Buffers 16-31 overflow flags sit in high register, bit 0 is buffer 16
// - Each pair control register: low byte even buffer, high byte odd buffer
// - Direction bit 1 makes a transmit buffer, 0 a receive buffer
// - Read-only aborted bit is 1 after abort, 0 after successful send
// - Read-only arbitration-lost bit sets when the message lost arbitration
// - Read-only transmit-error bit sets on bus error during sending
// - Setting send request clears aborted, arbitration-lost and error bits
// - Writing one queues the message; hardware clears request after success
// - Clearing a set send request aborts that message
// - Auto-remote enabled plus matching remote frame sets send request
// - Two-bit priority: 11 highest down to 00 lowest
// - Message contents live in DMA RAM, not in these registers
// - A store records the 5-bit matching filter number in the buffer
package cbs_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int NUM_MASK = 3;
  localparam int NUM_RXBUF = 32;
  localparam int NUM_TXBUF = 8;
  // Register offsets, one word each on the plain register port
  localparam logic [3:0] OFF_MASK_EID0 = 4'h0;
  localparam logic [3:0] OFF_MASK_EID1 = 4'h1;
  localparam logic [3:0] OFF_MASK_EID2 = 4'h2;
  localparam logic [3:0] OFF_FULL_LO = 4'h3;
  localparam logic [3:0] OFF_FULL_HI = 4'h4;
  localparam logic [3:0] OFF_OVF_LO = 4'h5;
  localparam logic [3:0] OFF_OVF_HI = 4'h6;
  localparam logic [3:0] OFF_PAIR_CTL0 = 4'h7;
  localparam logic [3:0] OFF_INT_STATUS = 4'hb;
  localparam logic [3:0] OFF_INT_MASK = 4'hc;
  // Fields of one control byte
  localparam int BIT_DIR = 7;
  localparam int BIT_ABT = 6;
  localparam int BIT_LARB = 5;
  localparam int BIT_ERR = 4;
  localparam int BIT_REQ = 3;
  localparam int BIT_AUTO_REMOTE_ANSWER_EN = 2;
  localparam int BIT_PRI = 0;
  localparam int ODD_SHIFT = 8;
  // Interrupt status bits
  localparam int INT_W = 6;
  localparam int IRQ_RX_STORE = 0;
  localparam int IRQ_RX_OVF = 1;
  localparam int IRQ_TX_DONE = 2;
  localparam int IRQ_TX_ABT = 3;
  localparam int IRQ_TX_LARB = 4;
  localparam int IRQ_TX_ERR = 5;
  // Reset values
  localparam logic [15:0] RST_MASK_EID = 16'h0000;
  localparam logic [15:0] RST_FLAGS = 16'h0000;
  localparam logic [7:0] RST_CTL_BYTE = 8'h00;
  localparam logic [5:0] RST_INT = 6'h00;
endpackage

// File: rtl/cbs_top.sv
// Buffer bookkeeping of the CAN controller: masks, full/overflow flags, buffer control
`timescale 1ns/10ps
module cbs_top #(
  parameter int NRX = cbs_pkg::NUM_RXBUF,
  parameter int NTX = cbs_pkg::NUM_TXBUF
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic irq,
  input wire logic [15:0] cmp_msg_eid,
  input wire logic [15:0] cmp_flt_eid,
  input wire logic [1:0] cmp_mask_sel,
  output logic cmp_eid_match,
  input wire logic rx_store,
  input wire logic [4:0] rx_buf_idx,
  input wire logic [4:0] rx_filter_hit,
  input wire logic rx_remote,
  input wire logic [2:0] rx_remote_buf,
  output logic mb_wr_en,
  output logic [4:0] mb_wr_buf,
  output logic [4:0] mb_wr_hitcode,
  input wire logic [2:0] tx_evt_buf,
  input wire logic tx_ok,
  input wire logic tx_lost,
  input wire logic tx_err,
  input wire logic tx_abort_done,
  output logic tx_req_valid,
  output logic [2:0] tx_req_buf,
  output logic [1:0] tx_req_pri,
  output logic [7:0] tx_abort_pend
);
  logic [15:0] mask_eid_r [cbs_pkg::NUM_MASK];
  logic [NRX-1:0] full_r;
  logic [NRX-1:0] ovf_r;
  logic [NTX-1:0] dir_r;
  logic [NTX-1:0] abt_r;
  logic [NTX-1:0] larb_r;
  logic [NTX-1:0] err_r;
  logic [NTX-1:0] req_r;
  logic [NTX-1:0] auto_remote_answer_en_r;
  logic [2*NTX-1:0] pri_r;
  logic [NTX-1:0] abort_pend_r;
  logic [5:0] int_stat_r;
  logic [5:0] int_mask_r;
  logic [5:0] int_evt;
  logic [15:0] rd_nxt;
  logic [NRX-1:0] full_nxt;
  logic [NRX-1:0] ovf_nxt;
  logic pick_valid;
  logic [2:0] pick_idx;
  logic [1:0] pick_pri;
  logic [NTX-1:0] sw_req_set;
  logic [NTX-1:0] sw_req_clr;
  logic [NTX-1:0] remote_set;
  logic [NTX-1:0] req_set;

  // Register word that holds control byte of buffer b
  function automatic logic ctl_hit(input logic [3:0] a, input int b);
    ctl_hit = (a == 4'(cbs_pkg::OFF_PAIR_CTL0 + 4'(b / 2)));
  endfunction

  // Control byte of buffer b as software sees it
  function automatic logic [7:0] ctl_byte(input int b);
    ctl_byte = {dir_r[b], abt_r[b], larb_r[b], err_r[b], req_r[b], auto_remote_answer_en_r[b], pri_r[2*b +: 2]};
  endfunction

  // Acceptance masks
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < cbs_pkg::NUM_MASK; i++)
        mask_eid_r[i] <= cbs_pkg::RST_MASK_EID;
    end
    else if (reg_wr && reg_addr <= cbs_pkg::OFF_MASK_EID2)
    begin
      mask_eid_r[reg_addr[1:0]] <= reg_wdata;
    end
  end

  // Reserved mask select 11 matches nothing, so a stray setting never accepts
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      cmp_eid_match <= 1'b0;
    else if (cmp_mask_sel == 2'h3)
      cmp_eid_match <= 1'b0;
    else
      cmp_eid_match <= ~|((cmp_msg_eid ^ cmp_flt_eid) & mask_eid_r[cmp_mask_sel]);
  end

  // Full and overflow flags; a store in the clearing cycle survives
  always_comb
  begin
    full_nxt = full_r;
    ovf_nxt = ovf_r;
    if (reg_wr && reg_addr == cbs_pkg::OFF_FULL_LO)
      full_nxt[15:0] = full_r[15:0] & reg_wdata;
    if (reg_wr && reg_addr == cbs_pkg::OFF_FULL_HI)
      full_nxt[31:16] = full_r[31:16] & reg_wdata;
    if (reg_wr && reg_addr == cbs_pkg::OFF_OVF_LO)
      ovf_nxt[15:0] = ovf_r[15:0] & reg_wdata;
    if (reg_wr && reg_addr == cbs_pkg::OFF_OVF_HI)
      ovf_nxt[31:16] = ovf_r[31:16] & reg_wdata;
    if (rx_store)
    begin
      full_nxt[rx_buf_idx] = 1'b1;
      if (full_r[rx_buf_idx])
        ovf_nxt[rx_buf_idx] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      full_r <= {NRX{1'b0}};
      ovf_r <= {NRX{1'b0}};
    end
    else
    begin
      full_r <= full_nxt;
      ovf_r <= ovf_nxt;
    end
  end

  // Filter hit code goes to the buffer in DMA RAM, not to a register here
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      mb_wr_en <= 1'b0;
      mb_wr_buf <= 5'h00;
      mb_wr_hitcode <= 5'h00;
    end
    else
    begin
      mb_wr_en <= rx_store;
      mb_wr_buf <= rx_buf_idx;
      mb_wr_hitcode <= rx_filter_hit;
    end
  end

  // Send request sources per buffer
  generate
    for (genvar b = 0; b < NTX; b++)
    begin : g_req
      localparam int SH = (b % 2) * cbs_pkg::ODD_SHIFT;
      assign sw_req_set[b] = reg_wr && ctl_hit(reg_addr, b) &&
        reg_wdata[SH + cbs_pkg::BIT_REQ] && !req_r[b];
      assign sw_req_clr[b] = reg_wr && ctl_hit(reg_addr, b) &&
        !reg_wdata[SH + cbs_pkg::BIT_REQ] && req_r[b];
      assign remote_set[b] = rx_remote && rx_remote_buf == 3'(b) && auto_remote_answer_en_r[b] &&
        !req_r[b];
      assign req_set[b] = sw_req_set[b] | remote_set[b];
    end
  endgenerate

  // Writable control fields
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      dir_r <= {NTX{1'b0}};
      auto_remote_answer_en_r <= {NTX{1'b0}};
      pri_r <= {2*NTX{1'b0}};
    end
    else
    begin
      for (int b = 0; b < NTX; b++)
      begin
        if (reg_wr && ctl_hit(reg_addr, b))
        begin
          dir_r[b] <= reg_wdata[(b % 2) * cbs_pkg::ODD_SHIFT + cbs_pkg::BIT_DIR];
          auto_remote_answer_en_r[b] <= reg_wdata[(b % 2) * cbs_pkg::ODD_SHIFT + cbs_pkg::BIT_AUTO_REMOTE_ANSWER_EN];
          pri_r[2*b +: 2] <= reg_wdata[(b % 2) * cbs_pkg::ODD_SHIFT + cbs_pkg::BIT_PRI +: 2];
        end
      end
    end
  end

  // Request bit and abort handshake; a new request outranks a same-cycle completion
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      req_r <= {NTX{1'b0}};
      abort_pend_r <= {NTX{1'b0}};
    end
    else
    begin
      for (int b = 0; b < NTX; b++)
      begin
        if (req_set[b])
          req_r[b] <= 1'b1;
        else if (sw_req_clr[b] || (tx_ok && tx_evt_buf == 3'(b)))
          req_r[b] <= 1'b0;
        if (sw_req_clr[b])
          abort_pend_r[b] <= 1'b1;
        else if ((tx_abort_done || tx_ok) && tx_evt_buf == 3'(b))
          abort_pend_r[b] <= 1'b0;
      end
    end
  end

  // Read-only transmit status; cleared when a request is raised
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      abt_r <= {NTX{1'b0}};
      larb_r <= {NTX{1'b0}};
      err_r <= {NTX{1'b0}};
    end
    else
    begin
      for (int b = 0; b < NTX; b++)
      begin
        if (req_set[b])
        begin
          abt_r[b] <= 1'b0;
          larb_r[b] <= 1'b0;
          err_r[b] <= 1'b0;
        end
        else if (tx_evt_buf == 3'(b))
        begin
          if (tx_abort_done)
            abt_r[b] <= 1'b1;
          else if (tx_ok)
            abt_r[b] <= 1'b0;
          if (tx_lost)
            larb_r[b] <= 1'b1;
          if (tx_err)
            err_r[b] <= 1'b1;
        end
      end
    end
  end

  // Only transmit-direction buffers with a request and no abort pending compete
  cbs_tx_pick #(
    .NBUF(NTX)
  ) u_pick (
    .pend(req_r & dir_r & ~abort_pend_r),
    .pri(pri_r),
    .pick_valid(pick_valid),
    .pick_idx(pick_idx),
    .pick_pri(pick_pri)
  );
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_req_valid <= 1'b0;
      tx_req_buf <= 3'h0;
      tx_req_pri <= 2'h0;
      tx_abort_pend <= 8'h00;
    end
    else
    begin
      tx_req_valid <= pick_valid;
      tx_req_buf <= pick_idx;
      tx_req_pri <= pick_pri;
      tx_abort_pend <= abort_pend_r;
    end
  end

  // Interrupt status, write one to clear, event wins over clear
  assign int_evt = {tx_err, tx_lost, tx_abort_done, tx_ok, rx_store & full_r[rx_buf_idx],
    rx_store};
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      int_stat_r <= cbs_pkg::RST_INT;
      int_mask_r <= cbs_pkg::RST_INT;
      irq <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == cbs_pkg::OFF_INT_STATUS)
        int_stat_r <= (int_stat_r & ~reg_wdata[5:0]) | int_evt;
      else
        int_stat_r <= int_stat_r | int_evt;
      if (reg_wr && reg_addr == cbs_pkg::OFF_INT_MASK)
        int_mask_r <= reg_wdata[5:0];
      irq <= |(int_stat_r & int_mask_r);
    end
  end

  // Read mux; data stands only in the cycle after the strobe
  always_comb
  begin
    rd_nxt = 16'h0000;
    case (reg_addr)
      cbs_pkg::OFF_MASK_EID0: rd_nxt = mask_eid_r[0];
      cbs_pkg::OFF_MASK_EID1: rd_nxt = mask_eid_r[1];
      cbs_pkg::OFF_MASK_EID2: rd_nxt = mask_eid_r[2];
      cbs_pkg::OFF_FULL_LO: rd_nxt = full_r[15:0];
      cbs_pkg::OFF_FULL_HI: rd_nxt = full_r[31:16];
      cbs_pkg::OFF_OVF_LO: rd_nxt = ovf_r[15:0];
      cbs_pkg::OFF_OVF_HI: rd_nxt = ovf_r[31:16];
      cbs_pkg::OFF_INT_STATUS: rd_nxt = {10'h000, int_stat_r};
      cbs_pkg::OFF_INT_MASK: rd_nxt = {10'h000, int_mask_r};
      default:
      begin
        for (int p = 0; p < NTX / 2; p++)
        begin
          if (ctl_hit(reg_addr, 2 * p))
            rd_nxt = {ctl_byte(2 * p + 1), ctl_byte(2 * p)};
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
      reg_rdata <= rd_nxt;
    else
      reg_rdata <= 16'h0000;
  end

  a_full_set: assert property (@(posedge clk_sys) disable iff (!resetn)
    rx_store |=> full_r[$past(rx_buf_idx)])
    else $error("full flag not set after store");
  a_ovf_set: assert property (@(posedge clk_sys) disable iff (!resetn)
    (rx_store && full_r[rx_buf_idx]) |=> ovf_r[$past(rx_buf_idx)])
    else $error("overflow flag not set on store to full buffer");
  a_ovf_only_full: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(ovf_r[16]) |-> $past(rx_store && rx_buf_idx == 5'h10 && full_r[16]))
    else $error("overflow of buffer 16 without store to a full buffer");
  a_full_w1_keep: assert property (@(posedge clk_sys) disable iff (!resetn)
    (reg_wr && reg_addr == cbs_pkg::OFF_FULL_LO && reg_wdata[0] && full_r[0]) |=> full_r[0])
    else $error("writing one changed a full flag");
  a_full_clr: assert property (@(posedge clk_sys) disable iff (!resetn)
    (reg_wr && reg_addr == cbs_pkg::OFF_FULL_HI && !reg_wdata[0] && !rx_store)
    |=> !full_r[16])
    else $error("written zero did not clear full flag of buffer 16");
  a_req_clears_st: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(req_r[4]) |-> !abt_r[4] && !larb_r[4] && !err_r[4])
    else $error("status bits survived a new send request");
  a_ok_clears_req: assert property (@(posedge clk_sys) disable iff (!resetn)
    (tx_ok && tx_evt_buf == 3'h1 && !req_set[1]) |=> !req_r[1])
    else $error("send request not cleared after success");
  a_abort_flow: assert property (@(posedge clk_sys) disable iff (!resetn)
    sw_req_clr[4] |=> !req_r[4] && abort_pend_r[4] ##1 tx_abort_pend[4])
    else $error("abort request not raised after clearing send request");
  a_remote_req: assert property (@(posedge clk_sys) disable iff (!resetn)
    (rx_remote && rx_remote_buf == 3'h6 && !auto_remote_answer_en_r[6] && !req_r[6] && !sw_req_set[6])
    |=> !req_r[6])
    else $error("remote frame set request with auto answer off");
  a_pick_pri: assert property (@(posedge clk_sys) disable iff (!resetn)
    (tx_req_valid && req_r[tx_req_buf] && dir_r[7] && req_r[7] && !abort_pend_r[7] &&
    $stable(pri_r) && $stable(req_r) && $stable(dir_r) && $stable(abort_pend_r))
    |-> tx_req_pri >= pri_r[15:14])
    else $error("lower priority buffer offered ahead of buffer 7");
  a_hit_code: assert property (@(posedge clk_sys) disable iff (!resetn)
    rx_store |=> mb_wr_en && mb_wr_hitcode == $past(rx_filter_hit))
    else $error("filter hit code not forwarded with store");
  a_rd_one_cycle: assert property (@(posedge clk_sys) disable iff (!resetn)
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data stood outside its cycle");
endmodule

// File: rtl/cbs_tx_pick.sv
// Transmit arbiter choosing the next pending buffer by priority
`timescale 1ns/10ps
module cbs_tx_pick #(
  parameter int NBUF = 8
) (
  input wire logic [NBUF-1:0] pend,
  input wire logic [2*NBUF-1:0] pri,
  output logic pick_valid,
  output logic [$clog2(NBUF)-1:0] pick_idx,
  output logic [1:0] pick_pri
);
  // Ascending scan with >= lets a later (higher) buffer win a tie
  always_comb
  begin
    pick_valid = 1'b0;
    pick_idx = '0;
    pick_pri = 2'h0;
    for (int i = 0; i < NBUF; i++)
    begin
      if (pend[i] && (!pick_valid || pri[2*i +: 2] >= pick_pri))
      begin
        pick_valid = 1'b1;
        pick_idx = i[$clog2(NBUF)-1:0];
        pick_pri = pri[2*i +: 2];
      end
    end
  end
endmodule

// File: tb/cbs_engine_model.sv
// Behavioural model of the CAN engine that sends, aborts and reports per buffer
`timescale 1ns/10ps
module cbs_engine_model (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic en,
  input wire logic slow,
  input wire logic [1:0] mode,
  input wire logic tx_req_valid,
  input wire logic [2:0] tx_req_buf,
  input wire logic [7:0] tx_abort_pend,
  output logic [2:0] tx_evt_buf,
  output logic tx_ok,
  output logic tx_lost,
  output logic tx_err,
  output logic tx_abort_done
);
  logic [2:0] gap_r;
  // Gap lets the offer update before the next frame, as a real bus would
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      gap_r <= 3'h0;
      tx_evt_buf <= 3'h0;
      {tx_ok, tx_lost, tx_err, tx_abort_done} <= 4'h0;
    end
    else
    begin
      {tx_ok, tx_lost, tx_err, tx_abort_done} <= 4'h0;
      if (gap_r != 3'h0)
        gap_r <= gap_r - 3'h1;
      else if (en && tx_abort_pend != 8'h00)
      begin
        for (int i = 7; i >= 0; i--)
          if (tx_abort_pend[i])
            tx_evt_buf <= 3'(i);
        tx_abort_done <= 1'b1;
        gap_r <= slow ? 3'h7 : 3'h4;
      end
      else if (en && tx_req_valid)
      begin
        tx_evt_buf <= tx_req_buf;
        tx_ok <= mode == 2'd0;
        tx_lost <= mode == 2'd1;
        tx_err <= mode == 2'd2;
        gap_r <= slow ? 3'h7 : 3'h4;
      end
    end
  end
endmodule

// File: tb/testbench.sv
// Self-checking bench for the buffer status and control block
`timescale 1ns/10ps
module testbench;
  logic clk_sys, resetn, reg_wr, reg_rd, cmp_eid_match, rx_store, rx_remote, mb_wr_en, irq;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, cmp_msg_eid, cmp_flt_eid, r, f;
  logic [1:0] cmp_mask_sel, tx_req_pri, eng_mode, s;
  logic [4:0] rx_buf_idx, rx_filter_hit, mb_wr_buf, mb_wr_hitcode;
  logic [2:0] rx_remote_buf, tx_evt_buf, tx_req_buf;
  logic tx_ok, tx_lost, tx_err, tx_abort_done, tx_req_valid, eng_en, eng_slow;
  logic [7:0] tx_abort_pend;
  logic [31:0] seed;
  logic [15:0] msk [4];
  logic [15:0] fl [4];
  logic [2:0] sent_q [$];
  logic [2:0] exp_order [5] = '{3'd7, 3'd1, 3'd5, 3'd0, 3'd2};
  int num_errors, tests_run;

  cbs_top u_dut (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
    .cmp_msg_eid, .cmp_flt_eid, .cmp_mask_sel, .cmp_eid_match, .rx_store, .rx_buf_idx,
    .rx_filter_hit, .rx_remote, .rx_remote_buf, .mb_wr_en, .mb_wr_buf, .mb_wr_hitcode,
    .tx_evt_buf, .tx_ok, .tx_lost, .tx_err, .tx_abort_done, .tx_req_valid, .tx_req_buf,
    .tx_req_pri, .tx_abort_pend);
  cbs_engine_model u_eng (.clk_sys, .resetn, .en(eng_en), .slow(eng_slow), .mode(eng_mode),
    .tx_req_valid, .tx_req_buf, .tx_abort_pend, .tx_evt_buf, .tx_ok, .tx_lost, .tx_err,
    .tx_abort_done);

  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction
  // Reserved select 3 never accepts; otherwise only masked-in bits must agree
  function automatic logic [15:0] exp_match(input logic [1:0] sel, input logic [15:0] m,
    input logic [15:0] a, input logic [15:0] b);
    return 16'((sel != 2'd3) && (((a ^ b) & m) == 16'h0));
  endfunction
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e, input string n);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(n, reg_rdata, e);
  endtask
  task automatic store(input logic [4:0] i, input logic [4:0] h);
    @(posedge clk_sys);
    rx_store <= 1'b1;
    rx_buf_idx <= i;
    rx_filter_hit <= h;
    @(posedge clk_sys);
    rx_store <= 1'b0;
    #1;
    chk("mb_wr", {mb_wr_en, 5'h00, mb_wr_buf, mb_wr_hitcode}, {1'b1, 5'h00, i, h});
    if (fl[i[4]][i[3:0]])
      fl[2 + i[4]][i[3:0]] = 1'b1;
    fl[i[4]][i[3:0]] = 1'b1;
  endtask
  task automatic remote(input logic [2:0] b);
    @(posedge clk_sys);
    rx_remote <= 1'b1;
    rx_remote_buf <= b;
    @(posedge clk_sys);
    rx_remote <= 1'b0;
  endtask
  task automatic engine(input logic [1:0] m, input int n);
    @(posedge clk_sys);
    eng_mode <= m;
    eng_en <= 1'b1;
    tick(n);
    eng_en <= 1'b0;
    tick(8);
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
    if (tx_ok === 1'b1)
      sent_q.push_back(tx_evt_buf);
  // Bound at 50000 cycles, well above the whole sequence of about 500 cycles
  initial
  begin
    #2000000;
    num_errors++;
    report_and_stop();
  end

  initial
  begin
    seed = 32'h5abc61ac;
    num_errors = 0;
    tests_run = 0;
    {resetn, reg_wr, reg_rd, rx_store, rx_remote, eng_en, eng_slow} = 7'h00;
    {reg_addr, reg_wdata, cmp_msg_eid, cmp_flt_eid, cmp_mask_sel, eng_mode} = 56'h0;
    {rx_buf_idx, rx_filter_hit, rx_remote_buf} = 13'h0;
    fl = '{16'h0, 16'h0, 16'h0, 16'h0};
    msk[3] = 16'h0000;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int a = 0; a < 16; a++)
      rd_chk(4'(a), 16'h0000, "reset");
    wr(4'hd, 16'hffff);
    rd_chk(4'hd, 16'h0000, "unmapped");
    for (int m = 0; m < 3; m++)
    begin
      msk[m] = rnd();
      wr(4'(m), msk[m]);
      rd_chk(4'(m), msk[m], "mask");
    end
    for (int k = 0; k < 40; k++)
    begin
      s = 2'(k % 4);
      r = rnd();
      f = (k % 3 == 0) ? rnd() : r ^ (rnd() & ~msk[s]);
      @(posedge clk_sys);
      cmp_mask_sel <= s;
      cmp_msg_eid <= r;
      cmp_flt_eid <= f;
      @(posedge clk_sys);
      #1;
      chk("match", 16'(cmp_eid_match), exp_match(s, msk[s], r, f));
    end
    store(5'd17, 5'd5);
    store(5'd17, 5'd9);
    for (int k = 0; k < 24; k++)
      store(5'(rnd()), 5'(rnd()));
    for (int a = 0; a < 4; a++)
      rd_chk(4'(a + 3), fl[a], "flags");
    for (int a = 0; a < 4; a++)
    begin
      r = rnd();
      wr(4'(a + 3), r);
      fl[a] = fl[a] & r;
      rd_chk(4'(a + 3), fl[a], "clear");
    end
    rd_chk(4'hb, 16'h0003, "int_status");
    wr(4'hc, 16'h0002);
    tick(2);
    #1;
    chk("irq_on", 16'(irq), 16'h0001);
    wr(4'hb, 16'h0002);
    tick(2);
    #1;
    chk("irq_off", 16'(irq), 16'h0000);
    rd_chk(4'hb, 16'h0001, "int_w1c");
    wr(4'hb, 16'h0001);
    wr(4'hc, 16'h003f);
    // Priority codes 3,3,2,1,0 with a tie; the receive-direction request is never offered
    wr(4'h7, 16'h8b89);
    wr(4'h8, 16'h0b88);
    wr(4'h9, 16'h8a00);
    wr(4'ha, 16'h8b00);
    tick(3);
    #1;
    chk("offer", {10'h0, tx_req_valid, tx_req_pri, tx_req_buf}, 16'h003f);
    engine(2'd0, 40);
    chk("sent", 16'(sent_q.size()), 16'd5);
    foreach (exp_order[k])
      chk("order", 16'(sent_q[k]), 16'(exp_order[k]));
    rd_chk(4'h7, 16'h8381, "ctl0");
    rd_chk(4'h8, 16'h0b80, "ctl1");
    rd_chk(4'h9, 16'h8200, "ctl2");
    wr(4'ha, 16'h8480);
    remote(3'd7);
    remote(3'd6);
    tick(3);
    rd_chk(4'ha, 16'h8c80, "remote");
    eng_slow <= 1'b1;
    engine(2'd0, 20);
    rd_chk(4'ha, 16'h8480, "remote_sent");
    eng_slow <= 1'b0;
    wr(4'h9, 16'h0088);
    wr(4'h9, 16'h0080);
    tick(2);
    #1;
    chk("abort_pend", 16'(tx_abort_pend), 16'h0010);
    engine(2'd0, 12);
    chk("abort_ack", 16'(tx_abort_pend), 16'h0000);
    rd_chk(4'h9, 16'h00c0, "aborted");
    wr(4'h9, 16'h0088);
    rd_chk(4'h9, 16'h0088, "req_clear");
    engine(2'd1, 12);
    rd_chk(4'h9, 16'h00a8, "lost");
    engine(2'd2, 12);
    rd_chk(4'h9, 16'h00b8, "bus_err");
    engine(2'd0, 12);
    rd_chk(4'h9, 16'h00b0, "done");
    wr(4'h9, 16'h0088);
    rd_chk(4'h9, 16'h0088, "req_clear2");
    rd_chk(4'hb, 16'h003c, "tx_status");
    chk("irq_tx", 16'(irq), 16'h0001);
    report_and_stop();
  end
endmodule
